// ### design/prs_pkg.sv
package prs_pkg;

   // Sizes of the route table and of the pin space.
   localparam int NUM_INPUTS = 20;
   localparam int CODE_W = 5;
   localparam int IDX_W = 5;
   localparam int PIN_SPACE = 24;
   localparam int PORT_A_PINS = 6;
   localparam int PORT_B_PINS = 4;
   localparam int PORT_C_PINS = 8;

   // Pin code layout: port in the upper two bits, pin number in the lower three.
   localparam int CODE_PORT_LSB = 3;
   localparam int CODE_PIN_W = 3;
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;

   // Port B pins start at bit four of their port.
   localparam int PORT_B_FIRST_PIN = 4;

   // Bit set for every code that names a pin present on the device.
   localparam logic [23:0] PIN_EXISTS = 24'hFFF03F;

   // Permitted-port masks: bit 0 is port A, bit 1 port B, bit 2 port C.
   localparam logic [2:0] ALLOW_AB = 3'h3;
   localparam logic [2:0] ALLOW_AC = 3'h5;
   localparam logic [2:0] ALLOW_BC = 3'h6;

   // Index of each routed peripheral input in the route table.
   localparam int IDX_EXT_IRQ = 0;
   localparam int IDX_T0_CLK = 1;
   localparam int IDX_T1_CLK = 2;
   localparam int IDX_T1_GATE = 3;
   localparam int IDX_T2_EXT = 4;
   localparam int IDX_T3_CLK = 5;
   localparam int IDX_T3_GATE = 6;
   localparam int IDX_T4_EXT = 7;
   localparam int IDX_T5_CLK = 8;
   localparam int IDX_T5_GATE = 9;
   localparam int IDX_T6_EXT = 10;
   localparam int IDX_MOD_LOW = 11;
   localparam int IDX_MOD_HIGH = 12;
   localparam int IDX_MOD_SRC = 13;
   localparam int IDX_CAPTURE1 = 14;
   localparam int IDX_CAPTURE2 = 15;
   localparam int IDX_CAPTURE3 = 16;
   localparam int IDX_CAPTURE4 = 17;
   localparam int IDX_WG1 = 18;
   localparam int IDX_WG2 = 19;

   // Power-on route codes, one per index, same for every package variant.
   localparam logic [4:0] RESET_CODE [NUM_INPUTS] = '{
      5'h02, 5'h02, 5'h05, 5'h04, 5'h05, 5'h15, 5'h14, 5'h11, 5'h10, 5'h13,
      5'h12, 5'h12, 5'h15, 5'h01, 5'h15, 5'h13, 5'h02, 5'h04, 5'h02, 5'h02
   };

   // Permitted ports, one per index.
   localparam logic [2:0] ALLOWED_PORTS [NUM_INPUTS] = '{
      ALLOW_AB, ALLOW_AB, ALLOW_AC, ALLOW_BC, ALLOW_AC, ALLOW_BC, ALLOW_AC,
      ALLOW_BC, ALLOW_AC, ALLOW_BC, ALLOW_BC, ALLOW_AC, ALLOW_AC, ALLOW_AC,
      ALLOW_BC, ALLOW_BC, ALLOW_BC, ALLOW_BC, ALLOW_BC, ALLOW_BC
   };

endpackage

// ### design/prs_route_mem.sv
`timescale 1ns/1ps

// Holds one route code per peripheral input, all visible at once for the selectors.
module prs_route_mem (
   // Clock, reset and enable.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Write port.
   input wire logic wr_en,
   input wire logic [prs_pkg::IDX_W-1:0] wr_idx,
   input wire logic [prs_pkg::CODE_W-1:0] wr_code,
   // Read port.
   input wire logic [prs_pkg::IDX_W-1:0] rd_idx,
   output logic [prs_pkg::CODE_W-1:0] rd_code,
   // All codes in parallel.
   output logic [prs_pkg::CODE_W-1:0] codes [prs_pkg::NUM_INPUTS]
);

   logic [prs_pkg::CODE_W-1:0] mem_q [prs_pkg::NUM_INPUTS];
   logic [prs_pkg::CODE_W-1:0] mem_d [prs_pkg::NUM_INPUTS];
   logic [prs_pkg::CODE_W-1:0] rd_q;
   logic [prs_pkg::CODE_W-1:0] rd_d;

   // Next contents; an index past the table is dropped so stray writes cannot alias.
   always_comb begin
      mem_d = mem_q;
      rd_d = rd_q;
      if (ce) begin
         if (wr_en && (int'(wr_idx) < prs_pkg::NUM_INPUTS)) begin
            mem_d[wr_idx] = wr_code;
         end
         if (int'(rd_idx) < prs_pkg::NUM_INPUTS) begin
            rd_d = mem_q[rd_idx];
         end else begin
            rd_d = '0;
         end
      end
   end

   // Reset loads each entry's power-on code.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mem_q <= prs_pkg::RESET_CODE;
         rd_q <= '0;
      end else begin
         mem_q <= mem_d;
         rd_q <= rd_d;
      end
   end

   assign rd_code = rd_q;
   assign codes = mem_q;

endmodule

// ### design/prs_route_mux.sv
`timescale 1ns/1ps

// Picks one pin level for one peripheral input; bad codes give low.
module prs_route_mux (
   // Pin levels indexed by route code.
   input wire logic [prs_pkg::PIN_SPACE-1:0] pin_vec,
   // Selection.
   input wire logic [prs_pkg::CODE_W-1:0] code,
   input wire logic [2:0] allowed,
   // Result.
   output logic level
);

   logic [1:0] port;
   logic legal;

   // Port field 11 has no port and fails the range check by itself.
   always_comb begin
      port = code[prs_pkg::CODE_W-1:prs_pkg::CODE_PORT_LSB];
      legal = (port != 2'h3) && allowed[port] && prs_pkg::PIN_EXISTS[code];
      level = legal & pin_vec[code];
   end

endmodule

// ### design/prs_input_select.sv
`timescale 1ns/1ps

module prs_input_select (
   // Clock, reset and enable.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Route code write.
   input wire logic cfg_we,
   input wire logic [prs_pkg::IDX_W-1:0] cfg_idx,
   input wire logic [prs_pkg::CODE_W-1:0] cfg_code,
   // Route code readback.
   input wire logic [prs_pkg::IDX_W-1:0] cfg_rd_idx,
   output logic [prs_pkg::CODE_W-1:0] cfg_rd_code,
   // Device pins, asynchronous.
   input wire logic [prs_pkg::PORT_A_PINS-1:0] pin_a,
   input wire logic [prs_pkg::PORT_B_PINS-1:0] pin_b,
   input wire logic [prs_pkg::PORT_C_PINS-1:0] pin_c,
   // Analog select bits, same clock.
   input wire logic [prs_pkg::PORT_A_PINS-1:0] analog_select_bit_a,
   input wire logic [prs_pkg::PORT_B_PINS-1:0] analog_select_bit_b,
   input wire logic [prs_pkg::PORT_C_PINS-1:0] analog_select_bit_c,
   // Port data reads.
   output logic [prs_pkg::PORT_A_PINS-1:0] port_a_level,
   output logic [prs_pkg::PORT_B_PINS-1:0] port_b_level,
   output logic [prs_pkg::PORT_C_PINS-1:0] port_c_level,
   // Routed peripheral inputs.
   output logic ext_irq_route,
   output logic timer0_clock_in,
   output logic timer1_clock_in,
   output logic timer1_gate_in,
   output logic timer2_ext_in,
   output logic timer3_clock_in,
   output logic timer3_gate_in,
   output logic timer4_ext_in,
   output logic timer5_clock_in,
   output logic timer5_gate_in,
   output logic timer6_ext_in,
   output logic modulator_low_carrier,
   output logic modulator_high_carrier,
   output logic modulator_source,
   output logic capture1_input,
   output logic capture2_input,
   output logic capture3_input,
   output logic capture4_input,
   output logic waveform_gen1_input,
   output logic waveform_gen2_input
);

   localparam int PIN_TOTAL = prs_pkg::PORT_A_PINS + prs_pkg::PORT_B_PINS + prs_pkg::PORT_C_PINS;

   logic [PIN_TOTAL-1:0] pins_raw;
   logic [PIN_TOTAL-1:0] sync1_q;
   logic [PIN_TOTAL-1:0] sync1_d;
   logic [PIN_TOTAL-1:0] sync2_q;
   logic [PIN_TOTAL-1:0] sync2_d;
   logic [PIN_TOTAL-1:0] analog_select_bit_all;
   logic [prs_pkg::PIN_SPACE-1:0] pin_vec;
   logic [prs_pkg::CODE_W-1:0] codes [prs_pkg::NUM_INPUTS];
   logic [prs_pkg::NUM_INPUTS-1:0] sel_level;
   logic [prs_pkg::NUM_INPUTS-1:0] periph_q;
   logic [prs_pkg::NUM_INPUTS-1:0] periph_d;
   logic [PIN_TOTAL-1:0] port_q;
   logic [PIN_TOTAL-1:0] port_d;

   // Pins gathered C, B, A from the top down.
   assign pins_raw = {pin_c, pin_b, pin_a};
   assign analog_select_bit_all = {analog_select_bit_c, analog_select_bit_b, analog_select_bit_a};

   // Two-stage synchroniser; only the second stage is read by other logic.
   always_comb begin
      sync1_d = sync1_q;
      sync2_d = sync2_q;
      if (ce) begin
         sync1_d = pins_raw;
         sync2_d = sync1_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // Place each pin at the position its route code names; gaps stay low.
   // The routed level is cut while the analog select bit is set; port reads keep it.
   always_comb begin
      pin_vec = '0;
      for (int i = 0; i < prs_pkg::PORT_A_PINS; i++) begin
         pin_vec[(int'(prs_pkg::PORT_A) << prs_pkg::CODE_PIN_W) + i] = sync2_q[i] & ~analog_select_bit_all[i];
      end
      for (int i = 0; i < prs_pkg::PORT_B_PINS; i++) begin
         pin_vec[(int'(prs_pkg::PORT_B) << prs_pkg::CODE_PIN_W) + prs_pkg::PORT_B_FIRST_PIN + i] =
            sync2_q[prs_pkg::PORT_A_PINS + i] & ~analog_select_bit_all[prs_pkg::PORT_A_PINS + i];
      end
      for (int i = 0; i < prs_pkg::PORT_C_PINS; i++) begin
         pin_vec[(int'(prs_pkg::PORT_C) << prs_pkg::CODE_PIN_W) + i] =
            sync2_q[prs_pkg::PORT_A_PINS + prs_pkg::PORT_B_PINS + i]
            & ~analog_select_bit_all[prs_pkg::PORT_A_PINS + prs_pkg::PORT_B_PINS + i];
      end
   end

   // Route table; reset loads the per-input defaults.
   // It holds input routes only, so output routing cannot disturb it.
   prs_route_mem u_mem (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .wr_en(cfg_we),
      .wr_idx(cfg_idx),
      .wr_code(cfg_code),
      .rd_idx(cfg_rd_idx),
      .rd_code(cfg_rd_code),
      .codes(codes)
   );

   // One selector per input, all reading the same pin vector and encoding.
   genvar g;
   generate
      for (g = 0; g < prs_pkg::NUM_INPUTS; g++) begin : g_sel
         prs_route_mux u_mux (
            .pin_vec(pin_vec),
            .code(codes[g]),
            .allowed(prs_pkg::ALLOWED_PORTS[g]),
            .level(sel_level[g])
         );
      end
   endgenerate

   // Output stage registers every selection together, so shared pins arrive in step.
   // Port reads use the synchronised level, independent of any routing.
   always_comb begin
      periph_d = periph_q;
      port_d = port_q;
      if (ce) begin
         periph_d = sel_level;
         port_d = sync2_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         periph_q <= '0;
         port_q <= '0;
      end else begin
         periph_q <= periph_d;
         port_q <= port_d;
      end
   end

   // Analog functions are wired to their pins outside this block and never pass here.
   assign port_a_level = port_q[prs_pkg::PORT_A_PINS-1:0];
   assign port_b_level = port_q[prs_pkg::PORT_A_PINS +: prs_pkg::PORT_B_PINS];
   assign port_c_level = port_q[prs_pkg::PORT_A_PINS + prs_pkg::PORT_B_PINS +: prs_pkg::PORT_C_PINS];

   // Named outputs taken straight from the output register.
   assign ext_irq_route = periph_q[prs_pkg::IDX_EXT_IRQ];
   assign timer0_clock_in = periph_q[prs_pkg::IDX_T0_CLK];
   assign timer1_clock_in = periph_q[prs_pkg::IDX_T1_CLK];
   assign timer1_gate_in = periph_q[prs_pkg::IDX_T1_GATE];
   assign timer2_ext_in = periph_q[prs_pkg::IDX_T2_EXT];
   assign timer3_clock_in = periph_q[prs_pkg::IDX_T3_CLK];
   assign timer3_gate_in = periph_q[prs_pkg::IDX_T3_GATE];
   assign timer4_ext_in = periph_q[prs_pkg::IDX_T4_EXT];
   assign timer5_clock_in = periph_q[prs_pkg::IDX_T5_CLK];
   assign timer5_gate_in = periph_q[prs_pkg::IDX_T5_GATE];
   assign timer6_ext_in = periph_q[prs_pkg::IDX_T6_EXT];
   assign modulator_low_carrier = periph_q[prs_pkg::IDX_MOD_LOW];
   assign modulator_high_carrier = periph_q[prs_pkg::IDX_MOD_HIGH];
   assign modulator_source = periph_q[prs_pkg::IDX_MOD_SRC];
   assign capture1_input = periph_q[prs_pkg::IDX_CAPTURE1];
   assign capture2_input = periph_q[prs_pkg::IDX_CAPTURE2];
   assign capture3_input = periph_q[prs_pkg::IDX_CAPTURE3];
   assign capture4_input = periph_q[prs_pkg::IDX_CAPTURE4];
   assign waveform_gen1_input = periph_q[prs_pkg::IDX_WG1];
   assign waveform_gen2_input = periph_q[prs_pkg::IDX_WG2];

endmodule

// ### verif/prs_sel_props.sv
`timescale 1ns/1ps

// Port-level checks on the selector; table contents are judged by the bench.
module prs_sel_props (
   // Clock and control.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Configuration.
   input wire logic cfg_we,
   input wire logic [4:0] cfg_idx,
   input wire logic [4:0] cfg_code,
   input wire logic [4:0] cfg_rd_idx,
   input wire logic [4:0] cfg_rd_code,
   // Pins, analog selects and results.
   input wire logic [3:0] pin_b,
   input wire logic [7:0] pin_c,
   input wire logic [3:0] analog_select_bit_b,
   input wire logic [7:0] analog_select_bit_c,
   input wire logic [3:0] port_b_level,
   input wire logic [7:0] port_c_level,
   input wire logic capture1_input
);
   logic [1:0] run_q;
   logic [1:0] run_d;

   default clocking @(posedge clk_sys); endclocking

   // Counts clean edges so pipeline checks wait until the synchroniser is full.
   always_comb begin
      run_d = (rst || !ce) ? 2'h0 : ((run_q == 2'h3) ? run_q : run_q + 2'h1);
   end
   always_ff @(posedge clk_sys) begin
      run_q <= run_d;
   end

   // Capture1 accepts ports B and C only; missing pins read low.
   function automatic logic cap1_exp(logic [4:0] code, logic [3:0] b, logic [7:0] c);
      if (code[4:3] == 2'h2) return c[code[2:0]];
      if (code[4:3] == 2'h1 && code[2]) return b[code[1:0]];
      return 1'b0;
   endfunction

   sequence s_cap1_write;
      ce && cfg_we && cfg_idx == 5'h0E;
   endsequence
   sequence s_cap1_hold;
      ce && !cfg_we && analog_select_bit_b == 4'h0 && analog_select_bit_c == 8'h00;
   endsequence

   a_port_c_sync: assert property (disable iff (rst) run_q == 2'h3 |-> port_c_level == $past(pin_c, 3))
      else $error("port C level wrong");
   a_port_b_sync: assert property (disable iff (rst) run_q == 2'h3 |-> port_b_level == $past(pin_b, 3))
      else $error("port B level wrong");
   a_route_follow: assert property (disable iff (rst) s_cap1_write ##1 s_cap1_hold |=>
      capture1_input == cap1_exp($past(cfg_code, 2), port_b_level, port_c_level))
      else $error("capture1 route wrong");
   a_readback_write: assert property (disable iff (rst) (ce && cfg_we && cfg_idx < 5'h14) ##1
      (ce && !cfg_we && cfg_rd_idx == $past(cfg_idx)) |=> cfg_rd_code == $past(cfg_code, 2))
      else $error("readback after write wrong");
   a_readback_range: assert property (disable iff (rst) ce && cfg_rd_idx >= 5'h14 |=> cfg_rd_code == 5'h00)
      else $error("readback past table not zero");
   a_ce_freeze: assert property (disable iff (rst) !ce |=>
      $stable(cfg_rd_code) && $stable(port_c_level) && $stable(capture1_input))
      else $error("state moved while disabled");
   a_analog_block: assert property (disable iff (rst)
      ce && (&analog_select_bit_b) && (&analog_select_bit_c) |=> !capture1_input)
      else $error("analog pin reached capture1");
   a_reset_clear: assert property (rst |=> !capture1_input && port_c_level == 8'h00 && cfg_rd_code == 5'h00)
      else $error("outputs not cleared by reset");
endmodule

bind prs_input_select prs_sel_props u_props (.*);

// ### verif/prs_pin_model.sv
`timescale 1ns/1ps

// Outside world at the pins; levels move on the falling edge, clear of sampling.
module prs_pin_model (
   // Clock.
   input wire logic clk_sys,
   // Wanted levels: port C, port B, port A.
   input wire logic [17:0] pin_pat,
   // Pins.
   output logic [5:0] pin_a,
   output logic [3:0] pin_b,
   output logic [7:0] pin_c
);
   // Pins are always driven, so no released level is modelled.
   initial {pin_c, pin_b, pin_a} = 18'h00000;
   always @(negedge clk_sys) begin
      {pin_c, pin_b, pin_a} <= pin_pat;
   end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps

// Bench acts as software; the pin model is the outside world.
module tb_top;
   logic clk_sys, rst, ce, cfg_we;
   logic [4:0] cfg_idx, cfg_code, cfg_rd_idx, cfg_rd_code;
   logic [17:0] pin_pat;
   logic [5:0] pin_a, an_a, lvl_a;
   logic [3:0] pin_b, an_b, lvl_b;
   logic [7:0] pin_c, an_c, lvl_c;
   logic [19:0] rt;
   int failures;
   int compares;
   // Power-on codes and route cases on high pins: index, code, level.
   logic [4:0] dflt [20] = '{5'h02, 5'h02, 5'h05, 5'h04, 5'h05, 5'h15, 5'h14, 5'h11, 5'h10, 5'h13,
      5'h12, 5'h12, 5'h15, 5'h01, 5'h15, 5'h13, 5'h02, 5'h04, 5'h02, 5'h02};
   logic [4:0] c_idx [8] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h0E, 5'h0E};
   logic [4:0] c_code [8] = '{5'h0D, 5'h05, 5'h10, 5'h08, 5'h18, 5'h06, 5'h17, 5'h0D};
   logic c_exp [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

   prs_pin_model u_pins (.clk_sys(clk_sys), .pin_pat(pin_pat), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));
   prs_input_select u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
      .cfg_code(cfg_code), .cfg_rd_idx(cfg_rd_idx), .cfg_rd_code(cfg_rd_code), .pin_a(pin_a), .pin_b(pin_b),
      .pin_c(pin_c), .analog_select_bit_a(an_a), .analog_select_bit_b(an_b), .analog_select_bit_c(an_c),
      .port_a_level(lvl_a), .port_b_level(lvl_b), .port_c_level(lvl_c), .ext_irq_route(rt[0]),
      .timer0_clock_in(rt[1]), .timer1_clock_in(rt[2]), .timer1_gate_in(rt[3]), .timer2_ext_in(rt[4]),
      .timer3_clock_in(rt[5]), .timer3_gate_in(rt[6]), .timer4_ext_in(rt[7]), .timer5_clock_in(rt[8]),
      .timer5_gate_in(rt[9]), .timer6_ext_in(rt[10]), .modulator_low_carrier(rt[11]),
      .modulator_high_carrier(rt[12]), .modulator_source(rt[13]), .capture1_input(rt[14]),
      .capture2_input(rt[15]), .capture3_input(rt[16]), .capture4_input(rt[17]),
      .waveform_gen1_input(rt[18]), .waveform_gen2_input(rt[19]));

   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One write, readback aimed at the same entry.
   task automatic wr(input logic [4:0] idx, input logic [4:0] code);
      @(negedge clk_sys);
      cfg_we = 1'b1;
      cfg_idx = idx;
      cfg_code = code;
      cfg_rd_idx = idx;
      @(negedge clk_sys);
      cfg_we = 1'b0;
   endtask
   // Pin model plus two sync stages plus output flop.
   task automatic settle();
      repeat (4) @(negedge clk_sys);
   endtask
   task automatic test_defaults();
      for (int i = 0; i < 20; i++) begin
         cfg_rd_idx = i[4:0];
         @(negedge clk_sys);
         chk(cfg_rd_code, dflt[i]);
      end
      $display("test defaults done");
   endtask
   // All pins high first shows every power-on route at once, with port A levels.
   // RC5 feeds three inputs at once; RA2 reaches only inputs allowing port A.
   task automatic test_pins();
      pin_pat = 18'h3FFFF;
      settle();
      chk(rt[4:0], 5'h17);
      chk(rt[9:5], 5'h1F);
      chk(rt[14:10], 5'h1F);
      chk(rt[19:15], 5'h01);
      chk({4'h0, lvl_a == 6'h3F}, 5'h01);
      pin_pat = 18'h08004;
      settle();
      chk({4'h0, rt[14]}, 5'h01);
      chk({4'h0, rt[5]}, 5'h01);
      chk({4'h0, rt[12]}, 5'h01);
      chk({4'h0, rt[0]}, 5'h01);
      chk({4'h0, rt[16]}, 5'h00);
      chk({4'h0, lvl_c[5]}, 5'h01);
      pin_pat = 18'h00000;
      settle();
      chk({4'h0, rt[14]}, 5'h00);
      $display("test pins done");
   endtask
   task automatic test_routes();
      for (int i = 0; i < 8; i++) begin
         pin_pat = 18'h3FFFF;
         wr(c_idx[i], c_code[i]);
         settle();
         chk({4'h0, rt[c_idx[i]]}, {4'h0, c_exp[i]});
         chk(cfg_rd_code, c_code[i]);
         pin_pat = 18'h00000;
         settle();
         chk({4'h0, rt[c_idx[i]]}, 5'h00);
      end
      $display("test routes done");
   endtask
   // Analog select hides the pin from routing but not from the port read.
   task automatic test_analog();
      wr(5'h0E, 5'h15);
      pin_pat = 18'h08000;
      {an_a, an_b, an_c} = 18'h3FFFF;
      settle();
      chk({4'h0, rt[14]}, 5'h00);
      chk({4'h0, lvl_c[5]}, 5'h01);
      {an_a, an_b, an_c} = 18'h00000;
      settle();
      chk({4'h0, rt[14]}, 5'h01);
      $display("test analog done");
   endtask
   // Writes with the enable low or past the table must leave the table alone.
   task automatic test_ce();
      ce = 1'b0;
      wr(5'h0F, 5'h17);
      ce = 1'b1;
      wr(5'h14, 5'h01);
      @(negedge clk_sys);
      chk(cfg_rd_code, 5'h00);
      cfg_rd_idx = 5'h0F;
      @(negedge clk_sys);
      chk(cfg_rd_code, 5'h13);
      // A reset in mid-run must bring back the power-on table over the earlier rewrite of entry zero.
      rst = 1'h1;
      cfg_rd_idx = 5'h00;
      pin_pat = 18'h00004;
      repeat (2) @(negedge clk_sys);
      rst = 1'h0;
      @(negedge clk_sys);
      chk(cfg_rd_code, 5'h02);
      settle();
      chk({4'h0, rt[0]}, 5'h01);
      chk({4'h0, rt[1]}, 5'h01);
      chk({4'h0, rt[14]}, 5'h00);
      $display("test enable done");
   endtask
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // About 150 cycles are needed; the watchdog allows far more.
   initial begin
      #1000000;
      failures++;
      $display("FAIL %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      {rst, ce, cfg_we, cfg_idx, cfg_code, cfg_rd_idx} = 18'h30000;
      {pin_pat, an_a, an_b, an_c} = 36'h0;
      failures = 0;
      compares = 0;
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      test_defaults();
      test_pins();
      test_routes();
      test_analog();
      test_ce();
      give_verdict();
   end
endmodule
